// >>> logic/interp_pkg.sv
// Purpose: shared constants for the polyphase interpolation filter
// Assumes: fixed widths; one 25 MHz clock
// Notes: preset weight sets come from a formula, not from stored values
package interp_pkg;

  localparam int SAMPLE_W = 12;
  localparam int WEIGHT_W = 12;
  localparam int UPSAMPLE_FACTOR = 2;
  localparam int TAPS = 8;
  localparam int PHASE_TAPS = TAPS / UPSAMPLE_FACTOR;
  localparam int OUT_W = SAMPLE_W + WEIGHT_W + $clog2(PHASE_TAPS);
  localparam int TAP_IDX_W = $clog2(TAPS);
  localparam int PHASE_W = $clog2(UPSAMPLE_FACTOR);
  localparam int PEND_W = $clog2(UPSAMPLE_FACTOR + 1);
  localparam int SET_SEL_W = 4;
  localparam int SWAP_LIMIT_CYCLES = 4;

  // register map (byte addresses)
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int CTRL_SWAP_BIT = 1;
  localparam int CTRL_HOLD_BIT = 2;
  localparam int STAT_PAGE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_STARTED_BIT = 2;
  localparam int STAT_READY_BIT = 3;
  localparam logic [31:0] WB_DAT_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    load_idle,
    load_copy,
    load_stream
  } load_state_t;

  // preset weight table; entry is (set + 1) times (tap + 1), so the taps of one set differ
  function automatic logic signed [WEIGHT_W-1:0] preset_weight(
    input logic [SET_SEL_W-1:0] set,
    input logic [TAP_IDX_W-1:0] idx
  );
    logic [WEIGHT_W-1:0] v;
    v = WEIGHT_W'((int'(set) + 1) * (int'(idx) + 1));
    return v;
  endfunction

endpackage

// >>> logic/interp_filter.sv
// Purpose: polyphase interpolation filter with two-page weight storage
// Assumes: source and recipient run on clk; wishbone master on clk
// Notes: mode chosen by parameters; unused mode inputs are ignored
`timescale 1ns/1ns
module interp_filter
  import interp_pkg::*;
#(
  parameter int weight_mode_type = 1,
  parameter int weight_set_count = 0
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sync_clear_n,
  // sample source
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  input wire logic sample_in_valid,
  output logic ready,
  // weight control
  input wire logic signed [WEIGHT_W-1:0] tap_weight_in,
  input wire logic tap_weight_in_valid,
  input wire logic tap_weight_reload_req,
  input wire logic [SET_SEL_W-1:0] weight_set_select,
  input wire logic weight_page_swap,
  output logic tap_weight_reload_done,
  // sample recipient
  input wire logic out_accept = 1'b1,
  output logic signed [OUT_W-1:0] filtered_out,
  output logic out_sample_valid,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam bit MODE_RELOAD = (weight_mode_type == 1);
  localparam bit MODE_MULTI = (weight_mode_type == 0) && (weight_set_count > 1);
  localparam bit MODE_CONST = !MODE_RELOAD && !MODE_MULTI;
  localparam logic [TAP_IDX_W-1:0] LAST_TAP = TAP_IDX_W'(TAPS - 1);
  localparam logic [PEND_W-1:0] PEND_FULL = PEND_W'(UPSAMPLE_FACTOR);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  load_state_t load_st_r;
  logic [TAP_IDX_W-1:0] load_idx_r;
  logic [SET_SEL_W-1:0] set_sel_r;
  logic auto_swap_r;
  logic started_r;
  logic act_page_r;
  logic signed [WEIGHT_W-1:0] weight_mem [2][TAPS];
  logic signed [SAMPLE_W-1:0] line_r [PHASE_TAPS];
  logic signed [SAMPLE_W-1:0] line_use [PHASE_TAPS];
  logic [PHASE_W-1:0] phase_r;
  logic [PEND_W-1:0] pend_r;
  logic [PEND_W-1:0] pend_nxt;
  logic [PHASE_W-1:0] phase_sel;
  logic signed [OUT_W-1:0] dot;
  logic cmd_reload_r;
  logic cmd_swap_r;
  logic hold_r;
  logic reload_cmd;
  logic swap_cmd;
  logic wr_en;
  logic signed [WEIGHT_W-1:0] wr_data;
  logic fill_last;
  logic take;
  logic emit;
  logic acc_ok;
  logic wb_req;
  logic wb_wr;
  logic ctrl_wr;

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  assign reload_cmd = tap_weight_reload_req | cmd_reload_r;
  assign acc_ok = out_accept & ~hold_r;
  assign take = sample_in_valid & ready;
  assign emit = acc_ok & (take | (pend_r != '0));

  always_comb begin
    wr_en = 1'b0;
    wr_data = '0;
    case (load_st_r)
      load_copy: begin
        wr_en = 1'b1;
        wr_data = preset_weight(set_sel_r, load_idx_r);
      end
      load_stream: begin
        wr_en = tap_weight_in_valid;
        wr_data = tap_weight_in;
      end
      default: begin
        wr_en = 1'b0;
        wr_data = '0;
      end
    endcase
  end

  assign fill_last = wr_en && (load_idx_r == LAST_TAP);

  // constant mode has no swap input; startup fills swap in by themselves
  assign swap_cmd = ((weight_page_swap | cmd_swap_r) & ~MODE_CONST)
                    | (fill_last & auto_swap_r);

  ////////////////////////////////////////////////////////////////////////////
  // spare page fill sequencer

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      load_st_r <= MODE_RELOAD ? load_idle : load_copy;
      load_idx_r <= '0;
      set_sel_r <= '0;
      auto_swap_r <= !MODE_RELOAD;
    end else if (!sync_clear_n) begin
      load_st_r <= load_idle;
      load_idx_r <= '0;
      set_sel_r <= '0;
      auto_swap_r <= 1'b0;
    end else begin
      case (load_st_r)
        load_idle: begin
          if (reload_cmd) begin
            load_idx_r <= '0;
            if (MODE_RELOAD) begin
              load_st_r <= load_stream;
            end else begin
              load_st_r <= load_copy;
              set_sel_r <= MODE_MULTI ? weight_set_select : '0;
              auto_swap_r <= MODE_CONST;
            end
          end
        end
        load_copy, load_stream: begin
          if (wr_en) begin
            load_idx_r <= load_idx_r + 1'b1;
          end
          if (fill_last) begin
            load_st_r <= load_idle;
            auto_swap_r <= 1'b0;
          end
        end
        default: begin
          load_st_r <= load_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tap_weight_reload_done <= 1'b0;
    end else if (!sync_clear_n) begin
      tap_weight_reload_done <= 1'b0;
    end else begin
      tap_weight_reload_done <= fill_last;
    end
  end

  // storage is cleared only by power-on reset; the fill sequence then loads it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < 2; p++) begin
        for (int t = 0; t < TAPS; t++) begin
          weight_mem[p][t] <= '0;
        end
      end
    end else if (wr_en) begin
      weight_mem[~act_page_r][load_idx_r] <= wr_data;
    end
  end

  // swap lands one edge after the command, well inside the four-cycle budget
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_page_r <= 1'b0;
    end else if (!sync_clear_n) begin
      act_page_r <= 1'b0;
    end else if (swap_cmd) begin
      act_page_r <= ~act_page_r;
    end
  end

  // outside reloadable mode the filter stays quiet until a filled page has been made active once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      started_r <= MODE_RELOAD;
    end else if (!sync_clear_n) begin
      started_r <= MODE_RELOAD;
    end else if (swap_cmd) begin
      started_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data path

  // the phase emitted at a take already sees the new sample
  always_comb begin
    line_use[0] = take ? sample_in : line_r[0];
    for (int k = 1; k < PHASE_TAPS; k++) begin
      line_use[k] = take ? line_r[k-1] : line_r[k];
    end
  end

  assign phase_sel = take ? '0 : phase_r;

  always_comb begin
    logic [TAP_IDX_W-1:0] ci;
    logic signed [OUT_W-1:0] prod;
    ci = '0;
    prod = '0;
    dot = '0;
    for (int k = 0; k < PHASE_TAPS; k++) begin
      ci = TAP_IDX_W'(k * UPSAMPLE_FACTOR) + TAP_IDX_W'(phase_sel);
      // widen both factors first, a product at operand width would lose its top bits
      prod = OUT_W'(line_use[k]) * OUT_W'(weight_mem[act_page_r][ci]);
      dot = dot + prod;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < PHASE_TAPS; k++) begin
        line_r[k] <= '0;
      end
    end else if (!sync_clear_n) begin
      for (int k = 0; k < PHASE_TAPS; k++) begin
        line_r[k] <= '0;
      end
    end else if (take) begin
      for (int k = 0; k < PHASE_TAPS; k++) begin
        line_r[k] <= line_use[k];
      end
    end
  end

  always_comb begin
    if (take) begin
      pend_nxt = PEND_FULL - PEND_W'(acc_ok);
    end else if (emit) begin
      pend_nxt = pend_r - 1'b1;
    end else begin
      pend_nxt = pend_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= '0;
    end else if (!sync_clear_n) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= '0;
    end else if (!sync_clear_n) begin
      phase_r <= '0;
    end else if (take) begin
      phase_r <= PHASE_W'(acc_ok);
    end else if (emit) begin
      phase_r <= phase_r + 1'b1;
    end
  end

  // ready returns as the last phase goes out, so a new take overlaps nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready <= 1'b0;
    end else if (!sync_clear_n) begin
      ready <= 1'b0;
    end else begin
      ready <= started_r && (pend_nxt == '0);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filtered_out <= '0;
      out_sample_valid <= 1'b0;
    end else if (!sync_clear_n) begin
      filtered_out <= '0;
      out_sample_valid <= 1'b0;
    end else begin
      out_sample_valid <= emit;
      if (emit) begin
        filtered_out <= dot;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack held one cycle

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes land at the edge that sees ack, the same edge at which the master lets go
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign ctrl_wr = wb_wr && (wb_adr_i == CTRL_OFS);

  // status layout kept in one place so the fields cannot drift apart
  function automatic logic [31:0] status_word(
    input logic page,
    input logic busy,
    input logic go,
    input logic rdy
  );
    logic [31:0] w;
    w = WB_DAT_RESET;
    w[STAT_PAGE_BIT] = page;
    w[STAT_BUSY_BIT] = busy;
    w[STAT_STARTED_BIT] = go;
    w[STAT_READY_BIT] = rdy;
    return w;
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // read data stands with the ack and is zero outside a read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= WB_DAT_RESET;
    end else begin
      wb_dat_o <= WB_DAT_RESET;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          CTRL_OFS: begin
            wb_dat_o[CTRL_HOLD_BIT] <= hold_r;
          end
          STATUS_OFS: begin
            wb_dat_o <= status_word(act_page_r, load_st_r != load_idle, started_r, ready);
          end
          default: begin
            wb_dat_o <= WB_DAT_RESET;
          end
        endcase
      end
    end
  end

  // command bits are self-clearing pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_reload_r <= 1'b0;
      cmd_swap_r <= 1'b0;
    end else if (!sync_clear_n) begin
      cmd_reload_r <= 1'b0;
      cmd_swap_r <= 1'b0;
    end else if (ctrl_wr) begin
      cmd_reload_r <= wb_dat_i[CTRL_RELOAD_BIT];
      cmd_swap_r <= wb_dat_i[CTRL_SWAP_BIT];
    end else begin
      cmd_reload_r <= 1'b0;
      cmd_swap_r <= 1'b0;
    end
  end

  // hold stalls output like a low accept and stays until rewritten or cleared by sync_clear_n
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_r <= 1'b0;
    end else if (!sync_clear_n) begin
      hold_r <= 1'b0;
    end else if (ctrl_wr) begin
      hold_r <= wb_dat_i[CTRL_HOLD_BIT];
    end
  end

endmodule

// >>> verification/interp_filter_asserts.sv
// Purpose: port checks for interp_filter
// Assumes: reloadable mode, factor 2
// Notes: bind at the foot
`timescale 1ns/1ns
module interp_filter_asserts (
  // clock and resets
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sync_clear_n,
  // source
  input wire logic sample_in_valid,
  input wire logic ready,
  // weights
  input wire logic tap_weight_in_valid,
  input wire logic tap_weight_reload_req,
  input wire logic tap_weight_reload_done,
  // recipient and bus
  input wire logic out_accept,
  input wire logic out_sample_valid,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !sync_clear_n);
  sequence s_take;
    sample_in_valid && ready && out_accept;
  endsequence
  sequence s_fill;
    tap_weight_reload_req ##1 tap_weight_in_valid [*8];
  endsequence
  a_ready_drop: assert property (sample_in_valid && ready |=> !ready)
    else $error("ready high after take");
  a_two_outputs: assert property (
    s_take ##1 out_accept |-> out_sample_valid ##1 (out_sample_valid && ready))
    else $error("phase outputs missing");
  a_idle_quiet: assert property (ready && !sample_in_valid |=> !out_sample_valid)
    else $error("output without sample");
  a_accept_cause: assert property (out_sample_valid |-> $past(out_accept))
    else $error("output without accept");
  a_stall_ready: assert property (!out_accept && !ready |=> !ready)
    else $error("ready during stall");
  a_fill_done: assert property (s_fill |=> tap_weight_reload_done)
    else $error("no done after fill");
  a_fill_early: assert property (
    tap_weight_reload_req ##1 tap_weight_in_valid [*7] |-> !tap_weight_reload_done)
    else $error("early done");
  a_done_pulse: assert property (tap_weight_reload_done |=> !tap_weight_reload_done)
    else $error("done too long");
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
endmodule
////////////////////
bind interp_filter interp_filter_asserts u_chk (.clk, .rst_b, .sync_clear_n,
  .sample_in_valid, .ready, .tap_weight_in_valid, .tap_weight_reload_req,
  .tap_weight_reload_done, .out_accept, .out_sample_valid, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// >>> verification/stream_peer.sv
// Purpose: sample source and recipient
// Assumes: ready is a register
// Notes: slow mode accepts one cycle in three
`timescale 1ns/1ns
module stream_peer
  import interp_pkg::*;
(
  // clock
  input wire logic clk,
  // source
  input wire logic ready,
  output logic signed [SAMPLE_W-1:0] sample_in,
  output logic sample_in_valid,
  // recipient
  output logic out_accept
);
  int slow = 0;
  int ph = 0;
  initial begin
    sample_in = 12'h000;
    sample_in_valid = 1'b0;
    out_accept = 1'b1;
  end
  always @(posedge clk) begin
    ph <= (ph + 1) % 3;
    out_accept <= (slow == 0) || (ph == 2);
  end
  ////////////////////
  // bad keeps valid up while ready is low, which must be ignored
  task automatic send(input logic signed [SAMPLE_W-1:0] v, input bit bad);
    do @(posedge clk); while (ready !== 1'b1);
    sample_in <= v;
    sample_in_valid <= 1'b1;
    @(posedge clk);
    sample_in <= ~v;
    if (bad) @(posedge clk);
    sample_in_valid <= 1'b0;
  endtask
endmodule

// >>> verification/interp_filter_tb.sv
// Purpose: self-checking bench for interp_filter
// Assumes: reloadable mode, weights 1..8
// Notes: impulse rows give the weights back scaled by three
`timescale 1ns/1ns
module interp_filter_tb;
  import interp_pkg::*;
  typedef struct {
    logic signed [SAMPLE_W-1:0] x;
    logic signed [OUT_W-1:0] y0;
    logic signed [OUT_W-1:0] y1;
  } row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sync_clear_n = 1'b1;
  logic signed [SAMPLE_W-1:0] sample_in;
  logic sample_in_valid, ready, out_accept, out_sample_valid, tap_weight_reload_done;
  logic signed [WEIGHT_W-1:0] tap_weight_in = 12'h000;
  logic tap_weight_in_valid = 1'b0;
  logic tap_weight_reload_req = 1'b0;
  logic weight_page_swap = 1'b0;
  logic signed [OUT_W-1:0] filtered_out;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o;
  logic signed [OUT_W-1:0] got [$];
  row_t rows [4];
  int n_mismatch = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  interp_filter u_dut (.clk, .rst_b, .sync_clear_n, .sample_in, .sample_in_valid, .ready,
    .tap_weight_in, .tap_weight_in_valid, .tap_weight_reload_req, .weight_set_select(4'h0),
    .weight_page_swap, .tap_weight_reload_done, .out_accept, .filtered_out,
    .out_sample_valid, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
    .wb_dat_i, .wb_dat_o, .wb_ack_o);
  stream_peer u_peer (.clk, .ready, .sample_in, .sample_in_valid, .out_accept);
  always @(posedge clk) if (out_sample_valid === 1'b1) got.push_back(filtered_out);
  ////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic run_rows(input bit bad);
    int t;
    for (int k = 0; k < 4; k++) begin
      u_peer.send(rows[k].x, bad);
      t = 0;
      while (got.size() < 2 && t < 50) begin
        @(posedge clk);
        t++;
      end
      cmp(32'(got.size()), 32'h2, "out count");
      while (got.size() < 2) got.push_back('x);
      cmp(32'(got.pop_front()), 32'(rows[k].y0), "phase0");
      cmp(32'(got.pop_front()), 32'(rows[k].y1), "phase1");
    end
    repeat (10) @(posedge clk);
    cmp(32'(got.size()), 32'h0, "extra out");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  initial begin
    for (int k = 0; k < 4; k++) begin
      rows[k].x = (k == 0) ? 12'h003 : 12'h000;
      rows[k].y0 = 26'(3 * (2 * k + 1));
      rows[k].y1 = 26'(3 * (2 * k + 2));
    end
    repeat (20) @(posedge clk);
    cmp(32'(ready), 32'h0, "reset ready");
    rst_b <= 1'b1;
    wb(1'b0, 4'h8, 32'h0);
    cmp(q, 32'h0, "unmapped");
    wb(1'b1, CTRL_OFS, 32'h4);
    wb(1'b0, CTRL_OFS, 32'h0);
    cmp(q, 32'h4, "hold");
    wb(1'b1, CTRL_OFS, 32'h0);
    @(posedge clk);
    tap_weight_reload_req <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tap_weight_reload_req <= 1'b0;
      tap_weight_in_valid <= 1'b1;
      tap_weight_in <= 12'(i + 1);
    end
    @(posedge clk);
    tap_weight_in_valid <= 1'b0;
    @(posedge clk);
    cmp(32'(tap_weight_reload_done), 32'h1, "done");
    wb(1'b0, STATUS_OFS, 32'h0);
    cmp(32'(q[STAT_PAGE_BIT]), 32'h0, "page kept");
    weight_page_swap <= 1'b1;
    @(posedge clk);
    weight_page_swap <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b0, STATUS_OFS, 32'h0);
    cmp(32'(q[STAT_PAGE_BIT]), 32'h1, "page swap");
    run_rows(1'b0);
    u_peer.slow = 1;
    run_rows(1'b1);
    u_peer.slow = 0;
    sync_clear_n <= 1'b0;
    @(posedge clk);
    sync_clear_n <= 1'b1;
    @(posedge clk);
    cmp(32'(filtered_out), 32'h0, "clear");
    results();
  end
endmodule
